// [rtl/cbpwm_unit.sv]
/*
 * Capture and full-bridge PWM unit with an 8-bit period timer.
 * Assumes APB from software, capture pin and CAN receive pulse from
 * outside; pin input is synchronised here, the CAN pulse is on mclk.
 */
// How it works
// [RULE1] Timer counts from zero up to period, then wraps to zero.
// [RULE2] Period register is read/write and resets to all ones.
// [RULE3] Timer output feeds only the PWM time base, never serial baud.
// [RULE4] Any capture mode change may set the capture flag spuriously. Here only a change between two capture modes (0100-0111) sets it.
// [RULE5] Four capture prescale choices come from the 4-bit mode field.
// [RULE6] Prescale counter clears when off, non-capture, or reset.
// [RULE7] Changing prescale keeps the counter and may raise the flag.
// [RULE8] Software should write zero before a new prescale mode.
// [RULE9] CAN capture select bit swaps pin trigger for CAN receive.
// [RULE10] Any CAN receive buffer reception triggers the time stamp.
// [RULE11] CAN codes: 0100/0101 each, 0110 fourth, 0111 sixteenth.
// [RULE12] Direction bit picks forward or reverse, next PWM cycle.
// [RULE13] On turn, outputs B and D go inactive before period end.
// [RULE14] On turn, outputs A and C swap before period end.
// [RULE15] Modulation resumes at the start of the next period.
// [RULE16] No dead-band delay on any bridge transition.
// [RULE17] Only one bridge output is modulated at a time.
// [RULE18] Software should cut duty for one period before reversing.
// [RULE19] Timer holds and makes no matches while run bit is clear.
// [RULE20] Qualified capture copies time base and sets capture flag.
// [RULE21] Timer flag sets after postscaled matches, enable or not.
`timescale 1ns/1ps
module cbpwm_unit
    import cbpwm_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capturePin,
    input wire logic canRxPulse,
    output cbpwm_pkg::cbpwm_bridge_s bridgeOut
);
    import cbpwm_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] ctrl;
        logic [7:0] period;
        logic [7:0] flags;
        logic [7:0] enables;
        logic [7:0] prio;
        logic [7:0] capCtl;
        logic [7:0] capRes;
        logic [7:0] bridge;
        logic [7:0] duty;
        logic [7:0] canIo;
        logic [1:0] pre;
        logic [3:0] post;
        logic [4:0] preCnt;
        logic pinSync1;
        logic pinSync2;
        logic pinLast;
        logic dirNow;
        cbpwm_br_e brState;
        cbpwm_bridge_s outs;
        logic [31:0] rdata;
    } cbpwm_state_s;

    cbpwm_state_s state_r;
    cbpwm_state_s state_nxt;

    function automatic logic isCapture(input logic [3:0] m);
        isCapture = (m >= CBPWM_CAP_FALL) && (m <= CBPWM_CAP_RISE16);
    endfunction

    // [RULE5] four prescale choices
    function automatic logic preMatch(input logic [3:0] m,
                                      input logic [4:0] c);
        case (m)
            CBPWM_CAP_RISE4: preMatch = (c >= CBPWM_PRE4_LAST);
            CBPWM_CAP_RISE16: preMatch = (c >= CBPWM_PRE16_LAST);
            default: preMatch = 1'b1;
        endcase
    endfunction

    logic apbWr;
    logic apbRd;
    logic tick;
    logic match;
    logic periodEnd;
    logic rawEvent;
    logic capFire;
    logic postDone;
    logic pwmHigh;
    logic [3:0] capMode;
    logic [3:0] newMode;

    assign apbWr = psel && penable && pwrite;
    assign apbRd = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = state_r.rdata;
    assign bridgeOut = state_r.outs;
    assign capMode = state_r.capCtl[3:0];

    always_comb
    begin
        state_nxt = state_r;
        newMode = pwdata[3:0];
        // ****************************************
        // Period timer with prescale
        // ****************************************
        tick = 1'b0;
        match = 1'b0;
        postDone = 1'b0;
        // [RULE19] run bit gate
        if (state_r.ctrl[CBPWM_CTRL_RUN])
        begin
            state_nxt.pre = state_r.pre + 2'd1;
            case (state_r.ctrl[CBPWM_CTRL_PS_LO +: 2])
                2'd0: tick = 1'b1;
                2'd1: tick = (state_r.pre[1:0] == 2'd3);
                default: tick = (state_r.pre[1:0] == 2'd3);
            endcase
        end
        // [RULE1] wrap on period
        if (tick)
        begin
            if (state_r.count == state_r.period)
            begin
                match = 1'b1;
                state_nxt.count = CBPWM_ZERO8;
            end
            else
            begin
                state_nxt.count = state_r.count + 8'd1;
            end
        end
        // [RULE21] postscaled flag
        if (match)
        begin
            if (state_r.post == state_r.ctrl[CBPWM_CTRL_POST_LO +: 4])
            begin
                postDone = 1'b1;
                state_nxt.post = 4'd0;
            end
            else
            begin
                state_nxt.post = state_r.post + 4'd1;
            end
        end
        // [RULE3] pre-postscaler match only drives the PWM base
        periodEnd = match;

        // ****************************************
        // Capture path
        // ****************************************
        state_nxt.pinSync1 = capturePin;
        state_nxt.pinSync2 = state_r.pinSync1;
        state_nxt.pinLast = state_r.pinSync2;
        // [RULE9] trigger source select
        if (state_r.canIo[CBPWM_CANIO_CAP])
        begin
            // [RULE10] any buffer, one pulse
            rawEvent = canRxPulse;
        end
        else if (capMode == CBPWM_CAP_FALL)
        begin
            rawEvent = state_r.pinLast && !state_r.pinSync2;
        end
        else
        begin
            rawEvent = !state_r.pinLast && state_r.pinSync2;
        end
        capFire = 1'b0;
        // [RULE6] cleared when not capturing
        if (!isCapture(capMode))
        begin
            state_nxt.preCnt = 5'd0;
        end
        else if (rawEvent)
        begin
            // [RULE11] every, fourth, sixteenth
            if (preMatch(capMode, state_r.preCnt))
            begin
                capFire = 1'b1;
                state_nxt.preCnt = 5'd0;
            end
            else
            begin
                state_nxt.preCnt = state_r.preCnt + 5'd1;
            end
        end
        // [RULE20] capture time base
        if (capFire)
        begin
            state_nxt.capRes = state_r.count;
            state_nxt.flags[CBPWM_FLAG_CAP] = 1'b1;
        end

        // ****************************************
        // Full-bridge output
        // ****************************************
        pwmHigh = state_r.count < state_r.duty;
        // [RULE12] direction taken on the next clock, modulation at period edge
        case (state_r.brState)
            BR_RUN:
            begin
                if (state_r.bridge[CBPWM_BR_DIR] != state_r.dirNow)
                begin
                    state_nxt.brState = BR_TURN;
                end
            end
            BR_TURN:
            begin
                // [RULE15] resume next period
                if (periodEnd)
                begin
                    state_nxt.brState = BR_RUN;
                end
            end
            default: state_nxt.brState = BR_RUN;
        endcase
        if (state_r.brState == BR_RUN)
        begin
            state_nxt.dirNow = state_r.bridge[CBPWM_BR_DIR];
        end
        // [RULE16] outputs switch directly, no dead band
        if (!state_r.bridge[CBPWM_BR_EN])
        begin
            state_nxt.outs = '0;
        end
        else if (state_nxt.brState == BR_TURN)
        begin
            // [RULE13] B and D inactive
            state_nxt.outs.outB = 1'b0;
            state_nxt.outs.outD = 1'b0;
            // [RULE14] A and C swap
            state_nxt.outs.outA = !state_r.bridge[CBPWM_BR_DIR];
            state_nxt.outs.outC = state_r.bridge[CBPWM_BR_DIR];
        end
        else
        begin
            // [RULE17] one modulated output
            state_nxt.outs.outA = !state_r.dirNow;
            state_nxt.outs.outC = state_r.dirNow;
            state_nxt.outs.outD = !state_r.dirNow && pwmHigh;
            state_nxt.outs.outB = state_r.dirNow && pwmHigh;
        end

        // ****************************************
        // APB slave, zero wait states
        // ****************************************
        if (apbRd)
        begin
            case (paddr)
                CBPWM_OFF_COUNT: state_nxt.rdata = {24'h0, state_r.count};
                CBPWM_OFF_CTRL: state_nxt.rdata = {24'h0, state_r.ctrl};
                CBPWM_OFF_PERIOD: state_nxt.rdata = {24'h0, state_r.period};
                CBPWM_OFF_FLAGS: state_nxt.rdata = {24'h0, state_r.flags};
                CBPWM_OFF_ENABLES:
                    state_nxt.rdata = {24'h0, state_r.enables};
                CBPWM_OFF_PRIO: state_nxt.rdata = {24'h0, state_r.prio};
                CBPWM_OFF_CAPCTL: state_nxt.rdata = {24'h0, state_r.capCtl};
                CBPWM_OFF_CAPRES: state_nxt.rdata = {24'h0, state_r.capRes};
                CBPWM_OFF_BRIDGE: state_nxt.rdata = {24'h0, state_r.bridge};
                CBPWM_OFF_DUTY: state_nxt.rdata = {24'h0, state_r.duty};
                CBPWM_OFF_CANIO: state_nxt.rdata = {24'h0, state_r.canIo};
                default: state_nxt.rdata = 32'h0;
            endcase
        end
        if (apbWr)
        begin
            case (paddr)
                CBPWM_OFF_COUNT: state_nxt.count = pwdata[7:0];
                CBPWM_OFF_CTRL: state_nxt.ctrl = {1'b0, pwdata[6:0]};
                // [RULE2] period write
                CBPWM_OFF_PERIOD: state_nxt.period = pwdata[7:0];
                CBPWM_OFF_FLAGS:
                begin
                    // Hardware set wins over software clear
                    state_nxt.flags = pwdata[7:0] & 8'h81;
                    if (capFire)
                    begin
                        state_nxt.flags[CBPWM_FLAG_CAP] = 1'b1;
                    end
                end
                CBPWM_OFF_ENABLES: state_nxt.enables = pwdata[7:0] & 8'h81;
                CBPWM_OFF_PRIO: state_nxt.prio = pwdata[7:0] & 8'h81;
                CBPWM_OFF_CAPCTL:
                begin
                    state_nxt.capCtl = {4'h0, newMode};
                    // [RULE4] change between two capture modes sets flag spuriously
                    // [RULE7] counter kept between capture modes
                    if (newMode != capMode && isCapture(capMode)
                        && isCapture(newMode))
                    begin
                        state_nxt.flags[CBPWM_FLAG_CAP] = 1'b1;
                    end
                end
                CBPWM_OFF_BRIDGE: state_nxt.bridge = pwdata[7:0] & 8'hC0;
                CBPWM_OFF_DUTY: state_nxt.duty = pwdata[7:0];
                CBPWM_OFF_CANIO: state_nxt.canIo = pwdata[7:0] & 8'h10;
                default: state_nxt.capRes = state_nxt.capRes;
            endcase
        end
        if (postDone)
        begin
            state_nxt.flags[CBPWM_FLAG_TMR] = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= '0;
            // [RULE2] all ones after reset
            state_r.period <= CBPWM_PERIOD_RST;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // A software write to the count overrides the wrap
    sequence runMatch;
        state_r.ctrl[CBPWM_CTRL_RUN] && tick && !apbWr
            && state_r.count == state_r.period;
    endsequence

    sequence dirFlip;
        state_r.brState == BR_RUN && state_r.bridge[CBPWM_BR_EN]
            && state_r.bridge[CBPWM_BR_DIR] != state_r.dirNow;
    endsequence

    // [RULE1] wrap to zero
    timer_wrap_a: assert property (runMatch // [RULE1]
        |=> state_r.count == CBPWM_ZERO8)
        else $error("timer did not wrap");
    // [RULE2] period reset value
    period_rst_a: assert property ($rose(arst_n) // [RULE2]
        |-> state_r.period == CBPWM_PERIOD_RST)
        else $error("period reset value wrong");
    // [RULE19] stopped timer
    timer_hold_a: assert property (!state_r.ctrl[CBPWM_CTRL_RUN] // [RULE19]
        && !apbWr |=> $stable(state_r.count))
        else $error("timer moved while stopped");
    // [RULE6] prescale cleared
    pre_clear_a: assert property (!isCapture(capMode) // [RULE6]
        |=> state_r.preCnt == '0)
        else $error("prescale not cleared");
    // [RULE20] stamp and flag
    cap_copy_a: assert property (capFire // [RULE20]
        |=> state_r.capRes == $past(state_r.count)
        && state_r.flags[CBPWM_FLAG_CAP])
        else $error("capture not taken");
    // [RULE11] every message
    can_src_a: assert property (state_r.canIo[CBPWM_CANIO_CAP] // [RULE11]
        && canRxPulse && capMode == CBPWM_CAP_FALL |-> capFire)
        else $error("can capture missed");
    // [RULE13] modulated legs off
    turn_bd_a: assert property (state_r.brState == BR_TURN // [RULE13]
        |-> !state_r.outs.outB && !state_r.outs.outD)
        else $error("modulated outputs active in turn");
    // [RULE14] legs swap on a turn
    turn_swap_a: assert property (dirFlip // [RULE14]
        |=> state_r.outs.outC == $past(state_r.bridge[CBPWM_BR_DIR])
        && state_r.outs.outA != state_r.outs.outC)
        else $error("bridge legs did not swap");
    // [RULE17] one modulated leg
    one_mod_a: assert property ( // [RULE17]
        !(state_r.outs.outB && state_r.outs.outD)
        && !(state_r.outs.outA && state_r.outs.outC))
        else $error("two bridge legs active");
    // [RULE21] postscaled flag
    post_flag_a: assert property (postDone // [RULE21]
        |=> state_r.flags[CBPWM_FLAG_TMR])
        else $error("timer flag not set");

endmodule

// [shared/cbpwm_pkg.sv]
/*
 * Package for the capture and bridge PWM unit: register offsets,
 * field positions, reset values, mode codes and carrier structs.
 * Assumes a 32-bit APB master on the single system clock.
 */
package cbpwm_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] CBPWM_OFF_COUNT = 8'h00;
    localparam logic [7:0] CBPWM_OFF_CTRL = 8'h04;
    localparam logic [7:0] CBPWM_OFF_PERIOD = 8'h08;
    localparam logic [7:0] CBPWM_OFF_FLAGS = 8'h0C;
    localparam logic [7:0] CBPWM_OFF_ENABLES = 8'h10;
    localparam logic [7:0] CBPWM_OFF_PRIO = 8'h14;
    localparam logic [7:0] CBPWM_OFF_CAPCTL = 8'h18;
    localparam logic [7:0] CBPWM_OFF_CAPRES = 8'h1C;
    localparam logic [7:0] CBPWM_OFF_BRIDGE = 8'h20;
    localparam logic [7:0] CBPWM_OFF_DUTY = 8'h24;
    localparam logic [7:0] CBPWM_OFF_CANIO = 8'h28;

    // ****************************************
    // Reset values and field positions
    // ****************************************
    localparam logic [7:0] CBPWM_PERIOD_RST = 8'hFF;
    localparam logic [7:0] CBPWM_ZERO8 = 8'h00;
    localparam int CBPWM_CTRL_RUN = 2;
    localparam int CBPWM_CTRL_PS_LO = 0;
    localparam int CBPWM_CTRL_POST_LO = 3;
    localparam int CBPWM_FLAG_TMR = 7;
    localparam int CBPWM_FLAG_CAP = 0;
    localparam int CBPWM_BR_DIR = 6;
    localparam int CBPWM_BR_EN = 7;
    localparam int CBPWM_CANIO_CAP = 4;

    // ****************************************
    // Capture mode codes
    // ****************************************
    localparam logic [3:0] CBPWM_CAP_FALL = 4'h4;
    localparam logic [3:0] CBPWM_CAP_RISE = 4'h5;
    localparam logic [3:0] CBPWM_CAP_RISE4 = 4'h6;
    localparam logic [3:0] CBPWM_CAP_RISE16 = 4'h7;
    localparam logic [4:0] CBPWM_PRE4_LAST = 5'h03;
    localparam logic [4:0] CBPWM_PRE16_LAST = 5'h0F;

    typedef struct packed {
        logic outA;
        logic outB;
        logic outC;
        logic outD;
    } cbpwm_bridge_s;

    typedef enum logic [1:0] {
        BR_RUN,
        BR_TURN
    } cbpwm_br_e;

endpackage

// [sim/cbpwm_drv_model.sv]
/*
 * Model of the external full-bridge power switch drivers.
 * Assumes registered bridge levels from the unit on mclk.
 */
`timescale 1ns/1ps
module cbpwm_drv_model
    import cbpwm_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire cbpwm_pkg::cbpwm_bridge_s bridgeIn,
    output logic [7:0] shootCount
);
    // ****************************************
    // Shoot-through watch
    // ****************************************
    // Both switches of one leg on shorts the supply
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            shootCount <= 8'h00;
        else if ((bridgeIn.outA && bridgeIn.outB) ||
                 (bridgeIn.outC && bridgeIn.outD))
            shootCount <= shootCount + 8'h01;
    end
endmodule

// [sim/cbpwm_unit_bench.sv]
/*
 * Self-checking bench for the capture and bridge PWM unit.
 * Assumes a zero-wait APB slave and registered bridge levels.
 */
`timescale 1ns/1ps
module cbpwm_unit_bench;
    import cbpwm_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic capturePin = 1'b0;
    logic canRxPulse = 1'b0;
    cbpwm_bridge_s bridgeOut;
    logic [7:0] shootCount;
    logic [31:0] rd;
    logic [31:0] prev;
    logic lastErr;
    int failCount = 0;
    int nCompared = 0;
    int cycles = 0;
    int hi [4];
    int gaps;

    cbpwm_unit i_cbpwm_unit (.mclk(mclk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capturePin(capturePin),
        .canRxPulse(canRxPulse), .bridgeOut(bridgeOut));
    cbpwm_drv_model i_cbpwm_drv_model (.mclk(mclk), .arst_n(arst_n),
        .bridgeIn(bridgeOut), .shootCount(shootCount));

    always #20 mclk = ~mclk;

    // Hang guard, far above the whole sequence
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failCount++;
            finalReport();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic finalReport();
        $display("Compared %0d, mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        nCompared++;
        if (got !== exp)
        begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Called just after a rising edge; holds until pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Ends once pready is seen high; the hang guard catches a stuck slave
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic pulse(input int n);
        repeat (n)
        begin
            canRxPulse <= 1'b1;
            @(posedge mclk);
            canRxPulse <= 1'b0;
            @(posedge mclk);
        end
        repeat (3) @(posedge mclk);
    endtask

    // Pin goes through a synchroniser, so allow it time
    task automatic pin(input logic v);
        capturePin <= v;
        repeat (6) @(posedge mclk);
    endtask

    task automatic watch(input int n);
        hi = '{0, 0, 0, 0};
        gaps = 0;
        repeat (n)
        begin
            @(negedge mclk);
            hi[0] += int'(bridgeOut.outA);
            hi[1] += int'(bridgeOut.outB);
            hi[2] += int'(bridgeOut.outC);
            hi[3] += int'(bridgeOut.outD);
            if (bridgeOut.outA === bridgeOut.outC)
                gaps++;
            if ($isunknown(bridgeOut))
                gaps++;
        end
        @(posedge mclk);
    endtask

    task automatic chkBridge(input int a, b, c, d);
        chk("out a", a, hi[0]);
        chk("out b", b, hi[1]);
        chk("out c", c, hi[2]);
        chk("out d", d, hi[3]);
        chk("dead band", 0, gaps); // no gap
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic tRegs();
        rdc("period rst", CBPWM_OFF_PERIOD,
            {24'h0, CBPWM_PERIOD_RST});
        rdc("count rst", CBPWM_OFF_COUNT, 32'h0); // start
        wr(CBPWM_OFF_PERIOD, 32'hA5);
        rdc("period rw", CBPWM_OFF_PERIOD, 32'hA5); // rw
        wr(8'h2C, 32'hFF);
        chk("slave error", 32'h0, {31'h0, lastErr});
        rdc("unmapped", 8'h2C, 32'h0);
    endtask

    task automatic tTimer();
        wr(CBPWM_OFF_PERIOD, 32'h3);
        wr(CBPWM_OFF_CTRL, 32'h4);
        apb(1'b0, CBPWM_OFF_COUNT, 32'h0);
        prev = rd;
        // Reads are three cycles apart over four states
        repeat (6)
        begin
            apb(1'b0, CBPWM_OFF_COUNT, 32'h0);
            chk("count wrap", (prev + 32'h3) & 32'h3, rd); // wrap
            prev = rd;
        end
        wr(CBPWM_OFF_CTRL, 32'h0);
        apb(1'b0, CBPWM_OFF_COUNT, 32'h0);
        prev = rd;
        wr(CBPWM_OFF_FLAGS, 32'h0);
        repeat (12) @(posedge mclk);
        rdc("count held", CBPWM_OFF_COUNT, prev); // hold
        rdc("no match", CBPWM_OFF_FLAGS, 32'h0); // no flag
        wr(CBPWM_OFF_CTRL, 32'h0C);
        repeat (12) @(posedge mclk);
        apb(1'b0, CBPWM_OFF_FLAGS, 32'h0);
        chk("tmr flag", 32'h80, rd & 32'h80); // postscale
        wr(CBPWM_OFF_CTRL, 32'h0);
        wr(CBPWM_OFF_PERIOD, {24'h0, CBPWM_PERIOD_RST});
        wr(CBPWM_OFF_COUNT, 32'h0);
        // Forty running edges hold exactly ten ticks in four
        wr(CBPWM_OFF_CTRL, 32'h5);
        repeat (37) @(posedge mclk);
        wr(CBPWM_OFF_CTRL, 32'h0);
        rdc("prescale 4", CBPWM_OFF_COUNT, 32'hA); // divided
    endtask

    task automatic tCan();
        logic [3:0] modes [4] = '{CBPWM_CAP_FALL, CBPWM_CAP_RISE,
                                  CBPWM_CAP_RISE4, CBPWM_CAP_RISE16};
        int cnt [4] = '{1, 1, 4, 16};
        wr(CBPWM_OFF_COUNT, 32'h5A);
        wr(CBPWM_OFF_CANIO, 32'h10);
        foreach (modes[i])
        begin
            wr(CBPWM_OFF_CAPCTL, 32'h0);
            wr(CBPWM_OFF_CAPCTL, {28'h0, modes[i]});
            wr(CBPWM_OFF_FLAGS, 32'h0);
            pulse(cnt[i] - 1);
            rdc("cap early", CBPWM_OFF_FLAGS, 32'h0);
            pulse(1);
            rdc("cap flag", CBPWM_OFF_FLAGS, 32'h1);
            rdc("cap value", CBPWM_OFF_CAPRES, 32'h5A); // stamp
        end
        wr(CBPWM_OFF_CAPRES, 32'h0);
        rdc("cap ro", CBPWM_OFF_CAPRES, 32'h5A); // read only
        wr(CBPWM_OFF_CAPCTL, 32'h0);
        wr(CBPWM_OFF_CAPCTL, 32'h6);
        pulse(2);
        wr(CBPWM_OFF_FLAGS, 32'h0);
        // Direct move between prescales, count kept
        wr(CBPWM_OFF_CAPCTL, 32'h7);
        rdc("stray flag", CBPWM_OFF_FLAGS, 32'h1);
        wr(CBPWM_OFF_FLAGS, 32'h0);
        pulse(13);
        rdc("pre kept", CBPWM_OFF_FLAGS, 32'h0); // kept count
        pulse(1);
        rdc("pre early", CBPWM_OFF_FLAGS, 32'h1);
    endtask

    task automatic tPin();
        wr(CBPWM_OFF_CAPCTL, 32'h0);
        wr(CBPWM_OFF_CAPCTL, 32'h5);
        wr(CBPWM_OFF_FLAGS, 32'h0);
        pin(1'b1);
        pin(1'b0);
        rdc("pin masked", CBPWM_OFF_FLAGS, 32'h0); // swap
        wr(CBPWM_OFF_CANIO, 32'h0);
        wr(CBPWM_OFF_FLAGS, 32'h0);
        pulse(1);
        rdc("can masked", CBPWM_OFF_FLAGS, 32'h0); // pin only
        pin(1'b1);
        rdc("pin rise", CBPWM_OFF_FLAGS, 32'h1);
        wr(CBPWM_OFF_CAPCTL, 32'h0);
        wr(CBPWM_OFF_CAPCTL, 32'h4);
        wr(CBPWM_OFF_FLAGS, 32'h0);
        pin(1'b0);
        rdc("pin fall", CBPWM_OFF_FLAGS, 32'h1); // falling
    endtask

    task automatic tBridge();
        wr(CBPWM_OFF_PERIOD, 32'h9);
        // Stamp value left above the period would delay the wrap
        wr(CBPWM_OFF_COUNT, 32'h0);
        wr(CBPWM_OFF_DUTY, 32'h3);
        wr(CBPWM_OFF_CTRL, 32'h4);
        wr(CBPWM_OFF_BRIDGE, 32'h80);
        repeat (12) @(posedge mclk);
        watch(20);
        chkBridge(20, 0, 0, 6); // forward
        wr(CBPWM_OFF_BRIDGE, 32'hC0);
        watch(1);
        chkBridge(0, 0, 1, 0);
        repeat (12) @(posedge mclk);
        watch(20);
        chkBridge(0, 6, 20, 0);
        chk("shoot", 32'h0, {24'h0, shootCount}); // one leg
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        tRegs();
        tTimer();
        tCan();
        tPin();
        tBridge();
        finalReport();
    end
endmodule
